// ===== logic/uhm_pkg.sv
// shared constants and types for the modem pin and interrupt logic
package uhm_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int REG_DW = 8;
   localparam int IDX_W = 2;

   // ---------------------------------------------------------------
   // register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_MCR = 2'h0;
   localparam logic [IDX_W-1:0] IDX_MSR = 2'h1;
   localparam logic [IDX_W-1:0] IDX_INT_STATUS = 2'h2;
   localparam logic [IDX_W-1:0] IDX_INT_MASK = 2'h3;
   localparam logic [APB_AW-1:0] OFS_MCR = {6'h00, IDX_MCR} << 2;
   localparam logic [APB_AW-1:0] OFS_MSR = {6'h00, IDX_MSR} << 2;
   localparam logic [APB_AW-1:0] OFS_INT_STATUS = {6'h00, IDX_INT_STATUS} << 2;
   localparam logic [APB_AW-1:0] OFS_INT_MASK = {6'h00, IDX_INT_MASK} << 2;
   localparam int IDX_LSB = 2;
   localparam int MAP_TOP = IDX_LSB + IDX_W;

   // ---------------------------------------------------------------
   // modem control and modem status fields
   // ---------------------------------------------------------------
   localparam int MCR_W = 5;
   localparam logic [MCR_W-1:0] MCR_RST = 5'h00;
   localparam int MCR_OUT_A_BIT = 2;
   localparam int MCR_OUT_B_BIT = 3;
   localparam int MCR_LOOP_BIT = 4;
   localparam int MSR_RING_RISE_BIT = 2;
   localparam int MSR_RING_LVL_BIT = 6;

   // ---------------------------------------------------------------
   // interrupt sources, one bit each in status and mask
   // ---------------------------------------------------------------
   localparam int INT_W = 4;
   localparam int INT_RX_ERR = 0;
   localparam int INT_RX_DATA = 1;
   localparam int INT_TX_EMPTY = 2;
   localparam int INT_MODEM = 3;
   localparam logic [INT_W-1:0] INT_RST = 4'h0;

   // ---------------------------------------------------------------
   // pin side
   // ---------------------------------------------------------------
   localparam int RX_OVERSAMPLE = 16;
   localparam int PIN_SYNC_W = 7;
   // {rclk, ring_n, rd, rd_n, cs, addr[1:0]} at their idle levels
   localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_RST = 7'h28;

   typedef enum logic [0:0]
   {
      PR_IDLE = 1'b0,
      PR_DRIVE = 1'b1
   } uhm_pin_state_t;

endpackage

// ===== logic/uhm_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module uhm_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // the first stage feeds only the second stage
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         meta_reg <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ===== logic/uhm_rclk_tick.sv
// turns the synchronised receiver clock into sample and bit ticks
`timescale 1ns/1ps
module uhm_rclk_tick
#(
   parameter int DIV = 16
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic rclk_lvl,
   output logic sample_tick,
   output logic bit_tick
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   logic rclk_prev_reg;
   logic [CW-1:0] phase_reg;
   logic rclk_edge;

   assign rclk_edge = rclk_lvl & ~rclk_prev_reg;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rclk_prev_reg <= 1'b0;
         sample_tick <= 1'b0;
         bit_tick <= 1'b0;
         phase_reg <= '0;
      end
      else
      begin
         rclk_prev_reg <= rclk_lvl;
         sample_tick <= rclk_edge;
         bit_tick <= rclk_edge && (phase_reg == CW'(DIV - 1));
         if (rclk_edge)
         begin
            phase_reg <= (phase_reg == CW'(DIV - 1)) ? '0 : phase_reg + 1'b1;
         end
      end
   end

endmodule

// ===== logic/uhm_modem_pins.sv
// modem pin, read strobe and interrupt logic with an apb register slave
//
// Overview of operation
// - irq output is high while any unmasked interrupt is pending, low otherwise.
// - receiver error, data or fifo timeout, transmit empty, modem change raise irq.
// - irq drops when software clears the pending bits, and on master reset.
// - each user output pin is driven low while its control bit is set and loopback is off.
// - user outputs go high on reset, in loopback, or with bit 2/3 clear.
// - receiver is timed from the receiver clock pin at sixteen times baud.
// - selected register drives the pin bus while selected and either strobe active.
// - master reset clears registers and forces outputs to their reset levels.
// - modem status bit 6 shows the present ring indicator level.
// - modem status bit 2 sets only on a low-to-high ring pin transition.
// - reading modem status clears the ring change bit.
// - ring change raises irq when the modem status interrupt is enabled.
`timescale 1ns/1ps
module uhm_modem_pins
   import uhm_pkg::*;
#(
   parameter int RCLK_DIV = RX_OVERSAMPLE
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_select,
   input wire logic read_strobe,
   input wire logic read_strobe_n,
   input wire logic [IDX_W-1:0] pin_addr,
   output logic [REG_DW-1:0] pin_data_out,
   output logic pin_data_oe,
   input wire logic rcv_clock,
   output logic rx_sample_tick,
   output logic rx_bit_tick,
   input wire logic ring_indicate_n,
   input wire logic fifo_mode,
   input wire logic rx_error_evt,
   input wire logic rx_data_evt,
   input wire logic rx_timeout_evt,
   input wire logic tx_empty_evt,
   output logic user_out_a_n,
   output logic user_out_b_n,
   output logic loopback,
   output logic irq
);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (RCLK_DIV < 2)
   begin : g_div_check
      $error("RCLK_DIV must be at least 2");
   end

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [REG_DW-1:0] reg_read
   (
      input logic [IDX_W-1:0] idx,
      input logic [MCR_W-1:0] modem_control_reg,
      input logic [REG_DW-1:0] msr,
      input logic [INT_W-1:0] sts,
      input logic [INT_W-1:0] msk
   );
      logic [REG_DW-1:0] v;
      v = '0;
      unique case (idx)
         IDX_MCR: v = {3'h0, modem_control_reg};
         IDX_MSR: v = msr;
         IDX_INT_STATUS: v = {4'h0, sts};
         IDX_INT_MASK: v = {4'h0, msk};
      endcase
      return v;
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_SYNC_W-1:0] pin_sync;
   logic rclk_s;
   logic ring_n_s;
   logic rd_s;
   logic rd_n_s;
   logic cs_s;
   logic [IDX_W-1:0] addr_s;

   // every pin passes two flops before any logic looks at it
   uhm_sync #(
      .WIDTH(PIN_SYNC_W),
      .RST_VAL(PIN_SYNC_RST)
   ) u_pin_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({rcv_clock, ring_indicate_n, read_strobe, read_strobe_n,
                 chip_select, pin_addr}),
      .sync_out(pin_sync)
   );

   assign {rclk_s, ring_n_s, rd_s, rd_n_s, cs_s, addr_s} = pin_sync;

   // ---------------------------------------------------------------
   // receiver clock
   // ---------------------------------------------------------------
   // the pin must toggle well below half of clock, or edges are lost
   uhm_rclk_tick #(
      .DIV(RCLK_DIV)
   ) u_rclk_tick (
      .clock(clock),
      .sys_rst(sys_rst),
      .rclk_lvl(rclk_s),
      .sample_tick(rx_sample_tick),
      .bit_tick(rx_bit_tick)
   );

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic apb_setup;
   logic apb_access;
   logic apb_hit;
   logic [IDX_W-1:0] apb_idx;
   logic apb_wr;
   logic apb_rd_msr;
   logic [APB_DW-1:0] prdata_reg;

   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable;
   assign apb_hit = (paddr[APB_AW-1:MAP_TOP] == '0);
   assign apb_idx = paddr[MAP_TOP-1:IDX_LSB];
   assign apb_wr = apb_access & pwrite & apb_hit;
   assign apb_rd_msr = apb_access & ~pwrite & apb_hit & (apb_idx == IDX_MSR);
   // zero wait states: data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = apb_access & ~apb_hit;
   assign prdata = prdata_reg;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [MCR_W-1:0] mcr_reg;
   logic [INT_W-1:0] int_status_reg;
   logic [INT_W-1:0] int_status_next;
   logic [INT_W-1:0] int_mask_reg;
   logic ring_rise_flag_reg;
   logic ring_n_prev_reg;
   logic ring_rise_pulse;
   logic ring_clear;
   logic [REG_DW-1:0] msr_view;
   logic [INT_W-1:0] int_set;
   logic [INT_W-1:0] int_w1c;
   uhm_pin_state_t pin_state_reg;
   logic pin_rd_act;
   logic pin_rd_start;

   assign loopback = mcr_reg[MCR_LOOP_BIT];

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         mcr_reg <= MCR_RST;
      end
      else if (apb_wr && apb_idx == IDX_MCR)
      begin
         mcr_reg <= pwdata[MCR_W-1:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         int_mask_reg <= INT_RST;
      end
      else if (apb_wr && apb_idx == IDX_INT_MASK)
      begin
         int_mask_reg <= pwdata[INT_W-1:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         prdata_reg <= '0;
      end
      else if (apb_setup)
      begin
         prdata_reg <= apb_hit ? {24'h000000, reg_read(apb_idx, mcr_reg, msr_view,
                                  int_status_reg, int_mask_reg)} : '0;
      end
   end

   // ---------------------------------------------------------------
   // ring indicator
   // ---------------------------------------------------------------
   // rising pin edge, seen on the synchronised copy only
   assign ring_rise_pulse = ring_n_s & ~ring_n_prev_reg;
   // an apb read clears only a flag it actually returned
   assign ring_clear = (apb_rd_msr & prdata_reg[MSR_RING_RISE_BIT]) |
                       (pin_rd_start & (addr_s == IDX_MSR));

   always_comb
   begin
      msr_view = '0;
      msr_view[MSR_RING_LVL_BIT] = ~ring_n_s;
      msr_view[MSR_RING_RISE_BIT] = ring_rise_flag_reg;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ring_n_prev_reg <= 1'b1;
      end
      else
      begin
         ring_n_prev_reg <= ring_n_s;
      end
   end

   // a new edge in the clearing cycle wins over the clear
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ring_rise_flag_reg <= 1'b0;
      end
      else if (ring_rise_pulse)
      begin
         ring_rise_flag_reg <= 1'b1;
      end
      else if (ring_clear)
      begin
         ring_rise_flag_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   always_comb
   begin
      int_set = '0;
      int_set[INT_RX_ERR] = rx_error_evt;
      // the timeout source exists only with the fifos on
      int_set[INT_RX_DATA] = rx_data_evt | (fifo_mode & rx_timeout_evt);
      int_set[INT_TX_EMPTY] = tx_empty_evt;
      int_set[INT_MODEM] = ring_rise_pulse;
      int_w1c = (apb_wr && apb_idx == IDX_INT_STATUS) ? pwdata[INT_W-1:0] : '0;
      int_status_next = (int_status_reg & ~int_w1c) | int_set;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         int_status_reg <= INT_RST;
      end
      else
      begin
         int_status_reg <= int_status_next;
      end
   end

   assign irq = |(int_status_reg & int_mask_reg);

   // ---------------------------------------------------------------
   // user outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         user_out_a_n <= 1'b1;
         user_out_b_n <= 1'b1;
      end
      else
      begin
         user_out_a_n <= ~(mcr_reg[MCR_OUT_A_BIT] & ~mcr_reg[MCR_LOOP_BIT]);
         user_out_b_n <= ~(mcr_reg[MCR_OUT_B_BIT] & ~mcr_reg[MCR_LOOP_BIT]);
      end
   end

   // ---------------------------------------------------------------
   // pin read port
   // ---------------------------------------------------------------
   // either strobe may be used; the host parks the other one idle
   assign pin_rd_act = cs_s & (rd_s | ~rd_n_s);
   assign pin_rd_start = (pin_state_reg == PR_IDLE) & pin_rd_act;
   assign pin_data_oe = (pin_state_reg == PR_DRIVE);

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pin_state_reg <= PR_IDLE;
      end
      else
      begin
         unique case (pin_state_reg)
            PR_IDLE:
               if (pin_rd_act)
               begin
                  pin_state_reg <= PR_DRIVE;
               end
            PR_DRIVE:
               if (!pin_rd_act)
               begin
                  pin_state_reg <= PR_IDLE;
               end
         endcase
      end
   end

   // data are frozen for the whole strobe so a slow host sees one value
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pin_data_out <= '0;
      end
      else if (pin_rd_start)
      begin
         pin_data_out <= reg_read(addr_s, mcr_reg, msr_view, int_status_reg, int_mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   sequence sq_mcr_out_a_on;
      apb_wr && apb_idx == IDX_MCR && pwdata[MCR_OUT_A_BIT] && !pwdata[MCR_LOOP_BIT];
   endsequence

   sequence sq_clear_all;
      apb_wr && apb_idx == IDX_INT_STATUS && pwdata[INT_W-1:0] == 4'hF && int_set == '0;
   endsequence

   sequence sq_pin_read;
      pin_rd_start ##1 pin_data_oe;
   endsequence

   AST_IRQ_FROM_ERR: assert property (rx_error_evt && int_mask_reg[INT_RX_ERR] |=> irq)
      else $error("masked-in receiver error did not raise irq");
   AST_IRQ_MASKED_LOW: assert property (int_mask_reg == '0 |-> !irq)
      else $error("irq high with every source masked");
   AST_IRQ_CLEARED: assert property (sq_clear_all |=> !irq)
      else $error("irq stayed high after all pending bits were cleared");
   AST_RESET_LEVELS: assert property ($fell(sys_rst) |-> !irq && user_out_a_n
                                     && user_out_b_n && !pin_data_oe && mcr_reg == MCR_RST)
      else $error("outputs not at reset levels after master reset");
   AST_OUT_A_LOW: assert property (sq_mcr_out_a_on |=> ##1 !user_out_a_n)
      else $error("first user output not driven low after its bit was set");
   AST_LOOP_HIGH: assert property ($past(loopback) |-> user_out_a_n && user_out_b_n)
      else $error("user outputs low during loopback");
   AST_RING_RISE: assert property ($rose(ring_n_s) |=> ring_rise_flag_reg)
      else $error("ring change bit not set on rising ring pin");
   AST_RING_FALL: assert property ($fell(ring_n_s) |=> !$rose(ring_rise_flag_reg))
      else $error("ring change bit set on falling ring pin");
   AST_MSR_CLEAR: assert property (apb_rd_msr && prdata_reg[MSR_RING_RISE_BIT]
                                  && !ring_rise_pulse |=> !ring_rise_flag_reg)
      else $error("ring change bit survived a modem status read");
   AST_RING_IRQ: assert property (ring_rise_pulse && int_mask_reg[INT_MODEM] |=> irq)
      else $error("enabled ring change did not raise irq");
   AST_PIN_DRIVE: assert property (sq_pin_read ##0 pin_rd_act |=> pin_data_oe)
      else $error("pin bus released while strobe still active");
   AST_RCLK_TICK: assert property ($rose(rclk_s) |=> rx_sample_tick)
      else $error("receiver clock edge gave no sample tick");

endmodule

// ===== dv/uhm_modem_model.sv
// far-side model: modem ring pin, receiver clock and pin read port master
`timescale 1ns/1ps
module uhm_modem_model
   import uhm_pkg::*;
(
   input wire logic clock,
   input wire logic [REG_DW-1:0] pin_data_out,
   input wire logic pin_data_oe,
   output logic chip_select,
   output logic read_strobe,
   output logic read_strobe_n,
   output logic [IDX_W-1:0] pin_addr,
   output logic rcv_clock,
   output logic ring_indicate_n
);
   initial
   begin
      chip_select = 1'b0;
      read_strobe = 1'b0;
      read_strobe_n = 1'b1;
      pin_addr = '0;
      rcv_clock = 1'b0;
      ring_indicate_n = 1'b1;
   end

   task automatic ring_set(input logic lvl);
      @(posedge clock);
      ring_indicate_n <= lvl;
   endtask

   // eight system clocks per period; stands low between bursts
   task automatic rclk_run(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge clock);
         rcv_clock <= 1'b1;
         repeat (4) @(posedge clock);
         rcv_clock <= 1'b0;
      end
   endtask

   // only one strobe is ever used per read, the other stays parked
   task automatic pin_read(input logic [IDX_W-1:0] idx, input logic use_n,
      output logic [REG_DW-1:0] d, output logic ok);
      int n;
      @(posedge clock);
      chip_select <= 1'b1;
      pin_addr <= idx;
      if (use_n)
         read_strobe_n <= 1'b0;
      else
         read_strobe <= 1'b1;
      n = 0;
      @(posedge clock);
      while (pin_data_oe !== 1'b1 && n < 10)
      begin
         @(posedge clock);
         n++;
      end
      // data are taken at the same edge that shows the bus driven
      ok = (pin_data_oe === 1'b1);
      d = pin_data_out;
      chip_select <= 1'b0;
      read_strobe <= 1'b0;
      read_strobe_n <= 1'b1;
      n = 0;
      @(posedge clock);
      while (pin_data_oe !== 1'b0 && n < 10)
      begin
         @(posedge clock);
         n++;
      end
      repeat (3) @(posedge clock);
   endtask
endmodule

// ===== dv/uhm_modem_pins_tb_top.sv
// self-checking bench for the modem pin, pin read and interrupt logic
`timescale 1ns/1ps
module uhm_modem_pins_tb_top
   import uhm_pkg::*;
;
   localparam int DIV = 16;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fifo_mode = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [APB_DW-1:0] pwdata = '0;
   logic [3:0] ev = 4'h0;
   logic [APB_DW-1:0] prdata;
   logic pready, pslverr, cs, rs, rs_n, rclk, ring_n, oe, smp, bit_t;
   logic out_a_n, out_b_n, loopback, irq;
   logic [IDX_W-1:0] pa;
   logic [REG_DW-1:0] pdo;
   logic [32:0] exp_q[$];
   int err_total = 0, check_count = 0, sc = 0, bc = 0;
   int sb[4] = '{INT_RX_ERR, INT_RX_DATA, INT_RX_DATA, INT_TX_EMPTY};

   uhm_modem_pins #(.RCLK_DIV(DIV)) u_uhm_modem_pins (.clock(clock), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select(cs),
      .read_strobe(rs), .read_strobe_n(rs_n), .pin_addr(pa), .pin_data_out(pdo),
      .pin_data_oe(oe), .rcv_clock(rclk), .rx_sample_tick(smp), .rx_bit_tick(bit_t),
      .ring_indicate_n(ring_n), .fifo_mode(fifo_mode), .rx_error_evt(ev[0]),
      .rx_data_evt(ev[1]), .rx_timeout_evt(ev[2]), .tx_empty_evt(ev[3]),
      .user_out_a_n(out_a_n), .user_out_b_n(out_b_n), .loopback(loopback), .irq(irq));

   uhm_modem_model u_uhm_modem_model (.clock(clock), .pin_data_out(pdo),
      .pin_data_oe(oe), .chip_select(cs), .read_strobe(rs), .read_strobe_n(rs_n),
      .pin_addr(pa), .rcv_clock(rclk), .ring_indicate_n(ring_n));

   // ---------------------------------------------------------------
   // clock, checking and closing
   // ---------------------------------------------------------------
   initial
   begin
      forever #50 clock = ~clock;
   end

   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
      check_count++;
      if (s !== e)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // read results are compared at the edge that completes the access
   always @(posedge clock)
   begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         chk("prdata", exp_q.pop_front(), {pslverr, prdata});
      if (smp === 1'b1)
         sc++;
      if (bit_t === 1'b1)
         bc++;
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      err_total++;
      close_out();
   end

   // ---------------------------------------------------------------
   // bus and event tasks
   // ---------------------------------------------------------------
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [APB_AW-1:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic pulse(input int i);
      @(posedge clock);
      ev[i] <= 1'b1;
      @(posedge clock);
      ev <= 4'h0;
   endtask

   task automatic settle();
      repeat (2) @(negedge clock);
   endtask

   initial
   begin
      logic [31:0] d;
      logic [REG_DW-1:0] pd;
      logic ok;
      void'($urandom(81));
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk("irq_rst", 33'h0, 33'(irq));
      chk("outs_rst", 33'h3, 33'({out_a_n, out_b_n}));
      for (int i = 0; i < 4; i++)
         rd(8'(i * 4), 33'h0);
      u_uhm_modem_model.rclk_run(2 * DIV);
      repeat (8) @(negedge clock);
      chk("sample_ticks", 33'(2 * DIV), 33'(sc));
      chk("bit_ticks", 33'h2, 33'(bc));
      $display("test reset_and_rclk done");
      for (int i = 0; i < 8; i++)
      begin
         d = $urandom;
         d[4:2] = i[2:0];
         apb(1'b1, OFS_MCR, d);
         settle();
         chk("out_a", 33'(!(d[2] && !d[4])), 33'(out_a_n));
         chk("out_b", 33'(!(d[3] && !d[4])), 33'(out_b_n));
         chk("loopback", 33'(d[4]), 33'(loopback));
         rd(OFS_MCR, {28'h0, d[4:0]});
      end
      $display("test user_outputs done");
      fifo_mode <= 1'b0;
      pulse(2);
      rd(OFS_INT_STATUS, 33'h0);
      fifo_mode <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         d = 32'h1 << sb[i];
         pulse(i);
         settle();
         chk("irq_masked", 33'h0, 33'(irq));
         rd(OFS_INT_STATUS, {1'b0, d});
         apb(1'b1, OFS_INT_MASK, d);
         settle();
         chk("irq_set", 33'h1, 33'(irq));
         apb(1'b1, OFS_INT_STATUS, d);
         settle();
         chk("irq_clr", 33'h0, 33'(irq));
         apb(1'b1, OFS_INT_MASK, 32'h0);
      end
      $display("test interrupts done");
      apb(1'b1, OFS_INT_MASK, 32'h1 << INT_MODEM);
      u_uhm_modem_model.ring_set(1'b0);
      repeat (5) @(negedge clock);
      chk("irq_ring_fall", 33'h0, 33'(irq));
      rd(OFS_MSR, 33'h40);
      u_uhm_modem_model.ring_set(1'b1);
      repeat (5) @(negedge clock);
      chk("irq_ring_rise", 33'h1, 33'(irq));
      rd(OFS_MSR, 33'h04);
      rd(OFS_MSR, 33'h00);
      rd(OFS_INT_STATUS, 33'h08);
      u_uhm_modem_model.ring_set(1'b0);
      u_uhm_modem_model.ring_set(1'b1);
      repeat (5) @(negedge clock);
      u_uhm_modem_model.pin_read(IDX_MSR, 1'b1, pd, ok);
      chk("pin_oe_n", 33'h1, 33'(ok));
      chk("pin_msr", 33'h04, 33'(pd));
      rd(OFS_MSR, 33'h00);
      apb(1'b1, OFS_MCR, 32'h0D);
      u_uhm_modem_model.pin_read(IDX_MCR, 1'b0, pd, ok);
      chk("pin_oe", 33'h1, 33'(ok));
      chk("pin_ctl", 33'h0D, 33'(pd));
      apb(1'b1, OFS_INT_STATUS, 32'hF);
      $display("test ring_and_pin_reads done");
      apb(1'b1, 8'h10, 32'hFF);
      rd(8'h10, {1'b1, 32'h0});
      rd(OFS_MCR, 33'h0D);
      apb(1'b1, OFS_INT_MASK, (32'h1 << INT_TX_EMPTY) | (32'h1 << INT_RX_ERR));
      pulse(0);
      pulse(3);
      settle();
      chk("irq_pre", 33'h1, 33'(irq));
      rd(OFS_INT_STATUS, 33'h05);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (4) @(negedge clock);
      chk("irq_mid_rst", 33'h0, 33'(irq));
      chk("outs_mid_rst", 33'h3, 33'({out_a_n, out_b_n}));
      @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      rd(OFS_MCR, 33'h0);
      rd(OFS_INT_MASK, 33'h0);
      $display("test refusal_and_reset done");
      close_out();
   end
endmodule
